// *** common/otp_prog_pkg.sv ***
// Purpose: Shared constants and carrier types for the OTP programming controller.
// Assumes: 20 MHz system clock; all waits counted in 1 us ticks.
// Notes:   Pin control and status travel as packed structs.
package otp_prog_pkg;

  // Array geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] FIRST_ADDR = 16'h0000;
  localparam logic [15:0] LAST_ADDR = 16'hFFFF;

  // Address line positions used in identification mode
  localparam int CODE_SEL_BIT = 0;
  localparam int ID_SEL_BIT = 9;

  // Clock and microsecond tick
  localparam int CLK_PERIOD_NS = 50;
  localparam int US_NS = 1000;
  localparam int TICK_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);

  // Wait times in microseconds
  localparam int TIMER_W = 8;
  localparam logic [7:0] PULSE_US = 8'h64;    // 100 us program pulse
  localparam logic [7:0] SETUP_US = 8'h02;    // Address, data and supply setup
  localparam logic [7:0] HOLD_US = 8'h02;     // Data and supply hold after pulse
  localparam logic [7:0] VCS_US = 8'h02;      // Core supply setup
  localparam logic [7:0] RECOVER_US = 8'h02;  // Program supply recovery before reads
  localparam logic [7:0] READ_US = 8'h02;     // Data valid wait plus pin sync margin

  // Retry limit of the verify loop
  localparam logic [3:0] MAX_RETRY = 4'hA;

  // Control levels on the memory's pins
  typedef struct packed {
    logic ce_n;      // Chip select, low during pulses and reads
    logic oe_n;      // Output enable logic level, low for reads
    logic vpp_en;    // Raises output enable pin to program voltage
    logic vcc_prog;  // Core supply at program level, else normal level
    logic vid_en;    // Raises id select address line to identification voltage
  } pin_ctl_t;

  localparam pin_ctl_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, vpp_en: 1'b0,
                                     vcc_prog: 1'b0, vid_en: 1'b0};

  // Result flags to the user side
  typedef struct packed {
    logic busy;
    logic done;   // One-cycle pulse at the end of any run
    logic pass;
    logic fail;
  } status_t;

  localparam status_t STATUS_IDLE = '{busy: 1'b0, done: 1'b0, pass: 1'b0, fail: 1'b0};

endpackage

// *** dv/otp_mem_model.sv ***
// Purpose: Behavioural model of the OTP memory on the controller pins.
// Assumes: Pins are logic levels; supply flags stand for voltages.
// Notes: Released data pins show the inverse of the last byte.
`timescale 1ns/100ps
`default_nettype none
module otp_mem_model
#(
  parameter logic [7:0] MAKER_CODE = 8'h3C,  // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h71  // Arbitrary value
)
(
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_data,
  input wire otp_prog_pkg::pin_ctl_t i_pins,
  output logic [7:0] o_data
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic drive;
  logic [7:0] value;

  // Blank array reads all ones
  initial
  begin
    for (int a = 0; a < 65536; a++)
      mem[a] = 8'hFF;
    last = 8'h00;
  end

  // A pulse under program supply clears bits
  always @(posedge i_pins.ce_n)
  begin
    if (i_pins.vpp_en && i_pins.vcc_prog)
      mem[i_addr] = mem[i_addr] & i_data;
  end

  // Read only with the supply pin at logic level
  assign drive = !i_pins.ce_n && !i_pins.oe_n && !i_pins.vpp_en;
  assign value = i_pins.vid_en ? (i_addr[0] ? DEVICE_CODE : MAKER_CODE) : mem[i_addr];
  always @(*)
  begin
    if (drive)
      last = value;
  end
  assign o_data = drive ? value : ~last;
endmodule
`default_nettype wire

// *** dv/otp_programmer_asserts.sv ***
// Purpose: Port timing checks for the OTP programming controller.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound into the design from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module otp_programmer_asserts
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_start_prog,
  input wire logic [15:0] o_addr,
  input wire logic [7:0] o_data_pins,
  input wire logic o_data_oe,
  input wire otp_prog_pkg::pin_ctl_t o_pins,
  input wire otp_prog_pkg::status_t o_status
);
  logic [11:0] low_cnt;

  // Counts cycles with chip select low
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      low_cnt <= 12'h000;
    else if (!o_pins.ce_n)
      low_cnt <= low_cnt + 12'h001;
    else
      low_cnt <= 12'h000;
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_start;
    !o_status.busy && i_start_prog;
  endsequence

  sequence s_pulse_end;
    $rose(o_pins.ce_n) && o_pins.vpp_en;
  endsequence

  // Pulse of 2002 cycles: 100 us plus the registered timer load and expiry
  a_pulse_width: assert property (s_pulse_end |-> low_cnt == 12'h7D2)
    else $error("program pulse width wrong");
  a_start_first: assert property (s_start |=> o_status.busy && o_addr == 16'h0000)
    else $error("run did not start at first address");
  a_vpp_setup: assert property ($rose(o_pins.vpp_en) |-> $past(o_pins.vcc_prog, 38))
    else $error("program supply raised before core supply");
  a_pulse_stable: assert property (!o_pins.ce_n && o_pins.vpp_en |->
    o_data_oe && $stable(o_addr) && $stable(o_data_pins))
    else $error("address or data moved in pulse");
  a_pulse_hold: assert property (s_pulse_end |=> $stable(o_addr) [*8])
    else $error("address moved right after pulse");
  a_no_verify: assert property (o_pins.vpp_en |-> o_pins.oe_n)
    else $error("read while program supply high");
  a_id_supply: assert property (!o_pins.ce_n && o_pins.vid_en |->
    !o_pins.vpp_en && !o_pins.vcc_prog && !o_pins.oe_n)
    else $error("bad supplies in id read");
  a_id_order: assert property ($fell(o_pins.ce_n) && o_pins.vid_en |-> !o_addr[0])
    else $error("id read did not start with maker byte");
  // Reads must find the data bus released by the controller
  a_read_release: assert property (!o_pins.oe_n |-> !o_data_oe)
    else $error("data driven during a read");
  // Within a run the address only steps by one or returns to the first location
  a_addr_step: assert property (o_status.busy && $changed(o_addr) |->
    (o_addr == $past(o_addr) + 16'h0001) || (o_addr == 16'h0000))
    else $error("address did not step by one");
  a_done_single: assert property (o_status.done |-> !o_status.busy ##1 !o_status.done)
    else $error("done not a single idle pulse");
  a_fail_idle: assert property (o_status.done && o_status.fail |->
    o_pins == otp_prog_pkg::PINS_IDLE)
    else $error("supplies still up after fail");
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Purpose: Self-checking bench for the OTP programming controller.
// Assumes: 20 MHz clock; a full array run is too long, so only its start is run.
// Notes: Id codes in the model are arbitrary values.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_start_prog = 1'b0;
  logic i_start_id = 1'b0;
  logic [7:0] i_src_data = 8'h00;
  logic [7:0] i_data_pins;
  logic [7:0] mem_data;
  logic [15:0] o_addr;
  logic [7:0] o_data_pins;
  logic o_data_oe;
  otp_prog_pkg::pin_ctl_t o_pins;
  otp_prog_pkg::status_t o_status;
  logic [15:0] o_fail_addr;
  logic [7:0] o_id_maker;
  logic [7:0] o_id_device;
  logic oe_seen = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int n;

  otp_programmer i_dut (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_start_prog(i_start_prog),
    .i_start_id(i_start_id), .i_src_data(i_src_data), .i_data_pins(i_data_pins),
    .o_addr(o_addr), .o_data_pins(o_data_pins), .o_data_oe(o_data_oe), .o_pins(o_pins),
    .o_status(o_status), .o_fail_addr(o_fail_addr), .o_id_maker(o_id_maker),
    .o_id_device(o_id_device));
  otp_mem_model i_mem (.i_addr(o_addr), .i_data(o_data_pins), .i_pins(o_pins), .o_data(mem_data));

  // Wire level: controller wins while it drives
  assign i_data_pins = o_data_oe ? o_data_pins : mem_data;
  always #25 i_clock = ~i_clock;

  function automatic logic [7:0] src(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  // Source byte follows the address one cycle later
  always @(posedge i_clock)
  begin
    i_src_data <= src(o_addr);
    if (!o_pins.oe_n)
      oe_seen <= 1'b1;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic end_sim;
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic step;
    @(posedge i_clock);
    #1;
  endtask

  task automatic wait_ce(input logic lvl);
    n = 0;
    while (o_pins.ce_n !== lvl)
    begin
      step;
      n++;
      if (n > 5000)
      begin
        miscompares++;
        end_sim;
      end
    end
  endtask

  task automatic do_reset;
    @(posedge i_clock);
    i_arst_n <= 1'b0;
    repeat (20) @(posedge i_clock);
    i_arst_n <= 1'b1;
    step;
  endtask

  task automatic t_idle;
    check("pins", 16'(o_pins), 16'(otp_prog_pkg::PINS_IDLE));
    check("status", 16'(o_status), 16'(otp_prog_pkg::STATUS_IDLE));
    check("addr", o_addr, 16'h0000);
    check("data_oe", 16'(o_data_oe), 16'h0000);
    check("fail_addr", o_fail_addr, 16'h0000);
    check("id regs", {o_id_maker, o_id_device}, 16'h0000);
  endtask

  // Id read with a refused program start while busy
  task automatic t_ident;
    @(posedge i_clock);
    i_start_id <= 1'b1;
    @(posedge i_clock);
    i_start_id <= 1'b0;
    i_start_prog <= 1'b1;
    @(posedge i_clock);
    i_start_prog <= 1'b0;
    #1;
    check("id vid_en", 16'(o_pins.vid_en), 16'h0001);
    n = 0;
    while (o_status.done !== 1'b1)
    begin
      step;
      n++;
      if (n > 1000)
      begin
        miscompares++;
        end_sim;
      end
    end
    check("maker", 16'(o_id_maker), 16'h003C);
    check("device", 16'(o_id_device), 16'h0071);
    check("id pass", 16'({o_status.pass, o_status.fail}), 16'h0002);
    check("id end pins", 16'(o_pins), 16'(otp_prog_pkg::PINS_IDLE));
  endtask

  // First two pulses of a programming run
  task automatic t_program;
    @(posedge i_clock);
    oe_seen <= 1'b0;
    i_start_prog <= 1'b1;
    @(posedge i_clock);
    i_start_prog <= 1'b0;
    #1;
    check("vcc_prog", 16'(o_pins.vcc_prog), 16'h0001);
    check("start addr", o_addr, otp_prog_pkg::FIRST_ADDR);
    wait_ce(1'b0);
    check("vpp_en", 16'(o_pins.vpp_en), 16'h0001);
    check("addr 0", o_addr, 16'h0000);
    check("data 0", 16'(o_data_pins), 16'(src(16'h0000)));
    wait_ce(1'b1);
    // The registered timer load and expiry add two cycles to the 100 us pulse
    check("pulse", 16'(n),
      16'(int'(otp_prog_pkg::PULSE_US) * otp_prog_pkg::TICK_CYCLES + 2));
    check("burn 0", 16'(i_mem.mem[0]), 16'(src(16'h0000)));
    check("ce between", 16'(o_pins.ce_n), 16'h0001);
    wait_ce(1'b0);
    check("addr 1", o_addr, 16'h0001);
    check("data 1", 16'(o_data_pins), 16'(src(16'h0001)));
    check("no reads", 16'(oe_seen), 16'h0000);
  endtask

  initial
  begin
    do_reset;
    t_idle;
    t_ident;
    t_program;
    do_reset;
    t_idle;
    t_ident;
    end_sim;
  end
endmodule

bind otp_programmer otp_programmer_asserts i_chk (.i_clock(i_clock), .i_arst_n(i_arst_n),
  .i_start_prog(i_start_prog), .o_addr(o_addr), .o_data_pins(o_data_pins),
  .o_data_oe(o_data_oe), .o_pins(o_pins), .o_status(o_status));
`default_nettype wire

// *** rtl/otp_programmer.sv ***
// Purpose: Programs and identifies a 64K x 8 one-time-programmable memory through its pins.
// Assumes: i_src_data is the source byte for o_addr, valid one cycle after o_addr changes.
// Notes:   Supply switches are logic levels to external regulators.
`timescale 1ns/100ps
`default_nettype none
module otp_programmer
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_start_prog,
  input wire logic i_start_id,
  input wire logic [7:0] i_src_data,
  input wire logic [7:0] i_data_pins,
  output logic [15:0] o_addr,
  output logic [7:0] o_data_pins,
  output logic o_data_oe,
  output otp_prog_pkg::pin_ctl_t o_pins,
  output otp_prog_pkg::status_t o_status,
  output logic [15:0] o_fail_addr,
  output logic [7:0] o_id_maker,
  output logic [7:0] o_id_device
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_VCC_UP,
    ST_VPP_UP,
    ST_P_LOAD,
    ST_P_SETUP,
    ST_P_PULSE,
    ST_P_HOLD,
    ST_V_RECOVER,
    ST_V_READ,
    ST_V_CHECK,
    ST_F_SETTLE,
    ST_F_READ,
    ST_F_CHECK,
    ST_ID_SETUP,
    ST_ID_READ
  } state_t;
  state_t state;
  logic verify_phase;
  logic [3:0] retries;
  logic [7:0] pins_meta;
  logic [7:0] pins_sync;
  logic [7:0] read_byte;
  logic timer_load;
  logic [7:0] timer_us;
  logic timer_done;
  logic at_last;
  assign at_last = (o_addr == otp_prog_pkg::LAST_ADDR);
  // Two-stage synchroniser on the data pins
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pins_meta <= 8'h00;
      pins_sync <= 8'h00;
    end
    else
    begin
      pins_meta <= i_data_pins;
      pins_sync <= pins_meta;
    end
  end

  us_timer wait_timer
  (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_load(timer_load),
    .i_us(timer_us),
    .o_done(timer_done)
  );
  // Sequencer: state, pins, address, retries and results
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= ST_IDLE;
      verify_phase <= 1'b0;
      retries <= 4'h0;
      read_byte <= 8'h00;
      timer_load <= 1'b0;
      timer_us <= 8'h00;
      o_addr <= 16'h0000;
      o_data_pins <= 8'h00;
      o_data_oe <= 1'b0;
      o_pins <= otp_prog_pkg::PINS_IDLE;
      o_status <= otp_prog_pkg::STATUS_IDLE;
      o_fail_addr <= 16'h0000;
      o_id_maker <= 8'h00;
      o_id_device <= 8'h00;
    end
    else
    begin
      timer_load <= 1'b0;
      o_status.done <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          if (i_start_prog)
          begin
            o_addr <= otp_prog_pkg::FIRST_ADDR;
            o_pins.vcc_prog <= 1'b1;
            verify_phase <= 1'b0;
            retries <= 4'h0;
            o_status <= '{busy: 1'b1, done: 1'b0, pass: 1'b0, fail: 1'b0};
            timer_us <= otp_prog_pkg::VCS_US;
            timer_load <= 1'b1;
            state <= ST_VCC_UP;
          end
          else if (i_start_id)
          begin
            o_addr <= otp_prog_pkg::FIRST_ADDR;
            o_pins.vid_en <= 1'b1;
            o_status <= '{busy: 1'b1, done: 1'b0, pass: 1'b0, fail: 1'b0};
            timer_us <= otp_prog_pkg::SETUP_US;
            timer_load <= 1'b1;
            state <= ST_ID_SETUP;
          end
        end
        ST_VCC_UP:
        begin
          if (timer_done)
          begin
            o_pins.vpp_en <= 1'b1;
            timer_us <= otp_prog_pkg::SETUP_US;
            timer_load <= 1'b1;
            state <= ST_VPP_UP;
          end
        end
        ST_VPP_UP:
        begin
          if (timer_done)
            state <= ST_P_LOAD;
        end
        // Address settles here; the source lookup answers one cycle later
        ST_P_LOAD:
        begin
          o_data_oe <= 1'b1;
          timer_us <= otp_prog_pkg::SETUP_US;
          timer_load <= 1'b1;
          state <= ST_P_SETUP;
        end
        ST_P_SETUP:
        begin
          o_data_pins <= i_src_data;
          if (timer_done)
          begin
            o_pins.ce_n <= 1'b0;
            timer_us <= otp_prog_pkg::PULSE_US;
            timer_load <= 1'b1;
            state <= ST_P_PULSE;
          end
        end
        ST_P_PULSE:
        begin
          if (timer_done)
          begin
            o_pins.ce_n <= 1'b1;
            timer_us <= otp_prog_pkg::HOLD_US;
            timer_load <= 1'b1;
            state <= ST_P_HOLD;
          end
        end
        ST_P_HOLD:
        begin
          if (timer_done)
          begin
            if (verify_phase || at_last)
            begin
              // Verify reads need the program supply off and the bus released
              o_data_oe <= 1'b0;
              o_pins.vpp_en <= 1'b0;
              verify_phase <= 1'b1;
              if (!verify_phase)
                o_addr <= otp_prog_pkg::FIRST_ADDR;
              timer_us <= otp_prog_pkg::RECOVER_US;
              timer_load <= 1'b1;
              state <= ST_V_RECOVER;
            end
            else
            begin
              o_addr <= o_addr + 16'h0001;
              state <= ST_P_LOAD;
            end
          end
        end
        ST_V_RECOVER:
        begin
          if (timer_done)
          begin
            o_pins.ce_n <= 1'b0;
            o_pins.oe_n <= 1'b0;
            timer_us <= otp_prog_pkg::READ_US;
            timer_load <= 1'b1;
            state <= ST_V_READ;
          end
        end
        ST_V_READ:
        begin
          if (timer_done)
          begin
            read_byte <= pins_sync;
            o_pins.ce_n <= 1'b1;
            o_pins.oe_n <= 1'b1;
            state <= ST_V_CHECK;
          end
        end
        ST_V_CHECK:
        begin
          if (read_byte == i_src_data)
          begin
            retries <= 4'h0;
            if (at_last)
            begin
              // Leave the program supplies for the final read-back
              o_pins.vcc_prog <= 1'b0;
              o_addr <= otp_prog_pkg::FIRST_ADDR;
              timer_us <= otp_prog_pkg::VCS_US;
              timer_load <= 1'b1;
              state <= ST_F_SETTLE;
            end
            else
            begin
              o_addr <= o_addr + 16'h0001;
              timer_us <= otp_prog_pkg::RECOVER_US;
              timer_load <= 1'b1;
              state <= ST_V_RECOVER;
            end
          end
          else if (retries == otp_prog_pkg::MAX_RETRY)
          begin
            o_pins <= otp_prog_pkg::PINS_IDLE;
            o_fail_addr <= o_addr;
            o_status <= '{busy: 1'b0, done: 1'b1, pass: 1'b0, fail: 1'b1};
            state <= ST_IDLE;
          end
          else
          begin
            retries <= retries + 4'h1;
            o_pins.vpp_en <= 1'b1;
            timer_us <= otp_prog_pkg::SETUP_US;
            timer_load <= 1'b1;
            state <= ST_VPP_UP;
          end
        end
        ST_F_SETTLE:
        begin
          if (timer_done)
          begin
            o_pins.ce_n <= 1'b0;
            o_pins.oe_n <= 1'b0;
            timer_us <= otp_prog_pkg::READ_US;
            timer_load <= 1'b1;
            state <= ST_F_READ;
          end
        end
        ST_F_READ:
        begin
          if (timer_done)
          begin
            read_byte <= pins_sync;
            state <= ST_F_CHECK;
          end
        end
        // Final comparison; chip stays selected while the address steps
        ST_F_CHECK:
        begin
          if (read_byte != i_src_data)
          begin
            o_pins <= otp_prog_pkg::PINS_IDLE;
            o_fail_addr <= o_addr;
            o_status <= '{busy: 1'b0, done: 1'b1, pass: 1'b0, fail: 1'b1};
            state <= ST_IDLE;
          end
          else if (at_last)
          begin
            o_pins <= otp_prog_pkg::PINS_IDLE;
            o_status <= '{busy: 1'b0, done: 1'b1, pass: 1'b1, fail: 1'b0};
            state <= ST_IDLE;
          end
          else
          begin
            o_addr <= o_addr + 16'h0001;
            timer_us <= otp_prog_pkg::READ_US;
            timer_load <= 1'b1;
            state <= ST_F_READ;
          end
        end
        ST_ID_SETUP:
        begin
          if (timer_done)
          begin
            o_pins.ce_n <= 1'b0;
            o_pins.oe_n <= 1'b0;
            timer_us <= otp_prog_pkg::READ_US;
            timer_load <= 1'b1;
            state <= ST_ID_READ;
          end
        end
        ST_ID_READ:
        begin
          if (timer_done)
          begin
            if (!o_addr[otp_prog_pkg::CODE_SEL_BIT])
            begin
              o_id_maker <= pins_sync;
              o_addr[otp_prog_pkg::CODE_SEL_BIT] <= 1'b1;
              timer_us <= otp_prog_pkg::READ_US;
              timer_load <= 1'b1;
            end
            else
            begin
              o_id_device <= pins_sync;
              o_pins <= otp_prog_pkg::PINS_IDLE;
              o_status <= '{busy: 1'b0, done: 1'b1, pass: 1'b1, fail: 1'b0};
              state <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/us_timer.sv ***
// Purpose: Microsecond wait timer for the programming controller.
// Assumes: Load and count come from logic on the same clock.
// Notes:   Reload restarts the prescaler, so a wait of N us is exactly N*20 cycles.
`timescale 1ns/100ps
`default_nettype none
module us_timer
(
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_load,
  input wire logic [7:0] i_us,
  output logic o_done
);

  logic [4:0] prescale;
  logic [7:0] remain;
  logic running;
  logic tick;

  assign tick = (prescale == otp_prog_pkg::TICK_LAST);

  // Prescaler giving a one-cycle enable every microsecond
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
      prescale <= 5'h00;
    else if (i_load || tick)
      prescale <= 5'h00;
    else
      prescale <= prescale + 5'h01;
  end

  // Countdown and one-cycle expiry pulse
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      remain <= 8'h00;
      running <= 1'b0;
      o_done <= 1'b0;
    end
    else if (i_load)
    begin
      remain <= i_us;
      running <= 1'b1;
      o_done <= 1'b0;
    end
    else if (running && tick)
    begin
      remain <= remain - 8'h01;
      running <= (remain != 8'h01);
      o_done <= (remain == 8'h01);
    end
    else
      o_done <= 1'b0;
  end

endmodule
`default_nettype wire
